// file: rtl/ep0_fifo_pkg.sv
package ep0_fifo_pkg;

   typedef logic [3:0] ptr_t;
   typedef logic [7:0] byte_t;

endpackage : ep0_fifo_pkg

// file: rtl/ep0_fifo_regs.svh
`ifndef EP0_FIFO_REGS_SVH
`define EP0_FIFO_REGS_SVH

// Register offsets
`define OFF_TX_FLAGS 8'h00
`define OFF_RX_DATA 8'h01
`define OFF_RX_LEN 8'h02
`define OFF_TX_DATA 8'h03
`define OFF_FIFO_CTL 8'h04
`define OFF_INT_STAT 8'h05
`define OFF_INT_MASK 8'h06

// Transmit flag bits
`define TXF_VACANT 3
`define TXF_FULL 2
`define TXF_UNDER 1
`define TXF_OVER 0

// Control register bits
`define CTL_RX_RESET 7
`define CTL_RX_EMPTY 6
`define CTL_RX_OVER 5
`define CTL_RX_UNDER 4
`define CTL_TX_CLEAR 0

// Interrupt bits
`define INT_TX 0
`define INT_RX 1

// Geometry and reset values
`define FIFO_DEPTH 8
`define RST_INT_MASK 2'h0

`endif

// file: rtl/ep0_fifo_status.sv
`timescale 1ns/1ps
`include "ep0_fifo_regs.svh"

module ep0_fifo_status
   import ep0_fifo_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic IRQ,
   input wire logic FN_TX_POP,
   output logic [7:0] FN_TX_DATA,
   input wire logic FN_RX_PUSH,
   input wire logic [7:0] FN_RX_DATA,
   input wire logic FN_RX_DONE,
   output logic FN_RX_FULL
);

   function automatic ptr_t fill(input ptr_t w, input ptr_t r);
      return ptr_t'(w - r);
   endfunction : fill

   function automatic logic hit(input byte_t a, input byte_t off);
      return a == off;
   endfunction : hit

   byte_t tx_mem [`FIFO_DEPTH];
   byte_t rx_mem [`FIFO_DEPTH];

   ptr_t tx_wptr_reg, tx_rptr_reg, rx_wptr_reg, rx_rptr_reg;
   ptr_t tx_wptr_next, tx_rptr_next, rx_wptr_next, rx_rptr_next;
   ptr_t rx_pkt_cnt_reg, rx_pkt_cnt_next;
   ptr_t rx_len_reg, rx_len_next;
   logic tx_under_reg, tx_under_next, tx_over_reg, tx_over_next;
   logic tx_clr_reg, tx_clr_next;
   logic rx_rst_reg, rx_rst_next;
   logic rx_over_reg, rx_over_next, rx_under_reg, rx_under_next;
   logic [1:0] int_stat_reg, int_stat_next;
   logic [1:0] int_mask_reg;
   byte_t rdata_reg, fn_tx_data_reg;
   logic irq_reg, fn_rx_full_reg;

   // Address decode
   wire logic rd_flags = RD && hit(ADDR, `OFF_TX_FLAGS);
   wire logic rd_rxd = RD && hit(ADDR, `OFF_RX_DATA);
   wire logic rd_len = RD && hit(ADDR, `OFF_RX_LEN);
   wire logic rd_ist = RD && hit(ADDR, `OFF_INT_STAT);
   wire logic wr_txd = WR && hit(ADDR, `OFF_TX_DATA);
   wire logic wr_ctl = WR && hit(ADDR, `OFF_FIFO_CTL);
   wire logic wr_msk = WR && hit(ADDR, `OFF_INT_MASK);

   // FIFO levels
   wire ptr_t tx_fill = fill(tx_wptr_reg, tx_rptr_reg);
   wire ptr_t rx_fill = fill(rx_wptr_reg, rx_rptr_reg);
   wire logic tx_empty = tx_fill == 4'h0;
   wire logic tx_full = tx_fill == ptr_t'(`FIFO_DEPTH);
   wire logic rx_empty = rx_fill == 4'h0;
   wire logic rx_full = rx_fill == ptr_t'(`FIFO_DEPTH);

   // Transmit side
   wire logic tx_push_ok = wr_txd && !tx_full && !tx_clr_reg;
   wire logic tx_pop_ok = FN_TX_POP && !tx_empty && !tx_clr_reg;
   wire logic ev_under = FN_TX_POP && tx_empty;
   wire logic ev_over = wr_txd && tx_full;
   assign tx_wptr_next = tx_clr_reg ? 4'h0 : tx_wptr_reg + ptr_t'(tx_push_ok);
   assign tx_rptr_next = tx_clr_reg ? 4'h0 : tx_rptr_reg + ptr_t'(tx_pop_ok);
   assign tx_under_next = (tx_under_reg && !tx_clr_reg) || ev_under;
   assign tx_over_next = (tx_over_reg && !tx_clr_reg) || ev_over;
   assign tx_clr_next = wr_ctl && WDATA[`CTL_TX_CLEAR];

   // Receive side
   wire logic rx_push_ok = FN_RX_PUSH && !rx_full && !rx_rst_reg;
   wire logic rx_pop_ok = rd_rxd && !rx_empty && !rx_rst_reg;
   wire ptr_t rx_pkt_sum = rx_pkt_cnt_reg + ptr_t'(rx_push_ok);
   wire byte_t rx_head = rx_mem[rx_rptr_reg[2:0]];
   assign rx_wptr_next = rx_rst_reg ? 4'h0 : rx_wptr_reg + ptr_t'(rx_push_ok);
   assign rx_rptr_next = rx_rst_reg ? 4'h0 : rx_rptr_reg + ptr_t'(rx_pop_ok);
   assign rx_over_next = (rx_over_reg && !rx_rst_reg) || (FN_RX_PUSH && rx_full);
   assign rx_under_next = (rx_under_reg && !rx_rst_reg) || (rd_rxd && rx_empty);
   assign rx_rst_next = wr_ctl && WDATA[`CTL_RX_RESET];
   assign rx_pkt_cnt_next = (FN_RX_DONE || rx_rst_reg) ? 4'h0 : rx_pkt_sum;
   assign rx_len_next = FN_RX_DONE ? rx_pkt_sum : rx_len_reg;

   // Sticky interrupt status, set wins over clear
   wire logic [1:0] int_set = {FN_RX_DONE, ev_under || ev_over};
   wire logic [1:0] int_clr = {rd_ist, rd_ist || tx_clr_reg};
   assign int_stat_next = (int_stat_reg & ~int_clr) | int_set;

   // Read data select, reserved bits zero
   wire byte_t flags_val = {4'h0, tx_empty, tx_full, tx_under_reg, tx_over_reg};
   wire byte_t ctl_val = {rx_rst_reg, rx_empty, rx_over_reg, rx_under_reg,
                          3'h0, tx_clr_reg};
   wire byte_t rd_sel =
      hit(ADDR, `OFF_TX_FLAGS) ? flags_val :
      hit(ADDR, `OFF_RX_DATA) ? (rx_pop_ok ? rx_head : 8'h00) :
      hit(ADDR, `OFF_RX_LEN) ? {4'h0, rx_len_reg} :
      hit(ADDR, `OFF_FIFO_CTL) ? ctl_val :
      hit(ADDR, `OFF_INT_STAT) ? {6'h00, int_stat_reg} :
      hit(ADDR, `OFF_INT_MASK) ? {6'h00, int_mask_reg} : 8'h00;

   always_ff @(posedge CLK) begin
      if (tx_push_ok) begin
         tx_mem[tx_wptr_reg[2:0]] <= WDATA;
      end
      if (rx_push_ok) begin
         rx_mem[rx_wptr_reg[2:0]] <= FN_RX_DATA;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_wptr_reg <= 4'h0;
         tx_rptr_reg <= 4'h0;
         tx_under_reg <= 1'b0;
         tx_over_reg <= 1'b0;
         tx_clr_reg <= 1'b0;
         fn_tx_data_reg <= 8'h00;
      end else begin
         tx_wptr_reg <= tx_wptr_next;
         tx_rptr_reg <= tx_rptr_next;
         tx_under_reg <= tx_under_next;
         tx_over_reg <= tx_over_next;
         tx_clr_reg <= tx_clr_next;
         if (tx_pop_ok) begin
            fn_tx_data_reg <= tx_mem[tx_rptr_reg[2:0]];
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_wptr_reg <= 4'h0;
         rx_rptr_reg <= 4'h0;
         rx_over_reg <= 1'b0;
         rx_under_reg <= 1'b0;
         rx_rst_reg <= 1'b0;
         rx_pkt_cnt_reg <= 4'h0;
         rx_len_reg <= 4'h0;
         fn_rx_full_reg <= 1'b0;
      end else begin
         rx_wptr_reg <= rx_wptr_next;
         rx_rptr_reg <= rx_rptr_next;
         rx_over_reg <= rx_over_next;
         rx_under_reg <= rx_under_next;
         rx_rst_reg <= rx_rst_next;
         rx_pkt_cnt_reg <= rx_pkt_cnt_next;
         rx_len_reg <= rx_len_next;
         fn_rx_full_reg <= fill(rx_wptr_next, rx_rptr_next) == ptr_t'(`FIFO_DEPTH);
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         int_stat_reg <= 2'h0;
         int_mask_reg <= `RST_INT_MASK;
         irq_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         int_stat_reg <= int_stat_next;
         if (wr_msk) begin
            int_mask_reg <= WDATA[1:0];
         end
         irq_reg <= |(int_stat_next & int_mask_reg);
         rdata_reg <= RD ? rd_sel : 8'h00;
      end
   end

   assign RDATA = rdata_reg;
   assign IRQ = irq_reg;
   assign FN_TX_DATA = fn_tx_data_reg;
   assign FN_RX_FULL = fn_rx_full_reg;

   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence flags_read_s;
      rd_flags ##1 1'b1;
   endsequence

   sequence rx_read_s;
      rd_rxd && !rx_empty && !rx_rst_reg;
   endsequence

   sequence tx_clear_s;
      wr_ctl && WDATA[`CTL_TX_CLEAR] ##1 tx_clr_reg;
   endsequence

   vacant_flag_a: assert property (flags_read_s |->
      RDATA[`TXF_VACANT] == ($past(tx_fill) == 4'h0))
      else $error("vacant flag wrong");

   full_flag_a: assert property (flags_read_s |->
      RDATA[`TXF_FULL] == ($past(tx_fill) == 4'h8))
      else $error("full flag wrong");

   underflow_set_a: assert property (FN_TX_POP && tx_fill == 4'h0 |=>
      tx_under_reg && int_stat_reg[`INT_TX])
      else $error("underflow not flagged");

   overflow_set_a: assert property (wr_txd && tx_fill == 4'h8 && !tx_clr_reg |=>
      tx_over_reg ##0 $stable(tx_wptr_reg))
      else $error("overflow not flagged");

   tx_int_a: assert property ($rose(tx_under_reg || tx_over_reg) |->
      int_stat_reg[`INT_TX])
      else $error("transmit interrupt missing");

   clear_over_a: assert property (tx_clear_s ##1 !$past(FN_TX_POP) && !$past(WR)
      |-> !tx_over_reg && !int_stat_reg[`INT_TX] && tx_fill == 4'h0 && !tx_clr_reg)
      else $error("clear left overflow");

   clear_under_a: assert property (tx_clr_reg && !FN_TX_POP
      |=> !tx_under_reg)
      else $error("clear left underflow");

   flags_ro_a: assert property (WR && hit(ADDR, `OFF_TX_FLAGS) && !FN_TX_POP
      && !tx_clr_reg |=> $stable(tx_under_reg) && $stable(tx_wptr_reg))
      else $error("flags written");

   rx_data_a: assert property (rx_read_s |=> RDATA == $past(rx_head)
      ##1 RDATA == 8'h00 || $past(RD))
      else $error("receive byte wrong");

   length_load_a: assert property (FN_RX_DONE && !rx_push_ok |=>
      rx_len_reg == $past(rx_pkt_cnt_reg) && rx_pkt_cnt_reg == 4'h0)
      else $error("length not loaded");

   length_hold_a: assert property (!FN_RX_DONE [*2] |-> ##1
      $stable(rx_len_reg))
      else $error("length moved");

   rx_reset_a: assert property (wr_ctl && WDATA[`CTL_RX_RESET] ##1
      !(wr_ctl && WDATA[`CTL_RX_RESET]) && !(FN_RX_PUSH && rx_full)
      |-> rx_rst_reg ##1 !rx_rst_reg && rx_fill == 4'h0 && !rx_over_reg)
      else $error("receive reset failed");

   rptr_step_a: assert property (RD && !hit(ADDR, `OFF_RX_DATA)
      && !rx_rst_reg |=> $stable(rx_rptr_reg))
      else $error("pointer moved");

   reserved_a: assert property (rd_len || rd_flags |=>
      RDATA[7:4] == 4'h0)
      else $error("reserved bits set");

   rdata_idle_a: assert property (!RD |=>
      RDATA == 8'h00)
      else $error("read data not idle");

   pop_step_a: assert property (rx_read_s |=>
      rx_rptr_reg == $past(rx_rptr_reg) + 4'h1)
      else $error("pointer step wrong");

   rx_under_set_a: assert property (rd_rxd && rx_empty |=>
      rx_under_reg)
      else $error("receive underflow missing");

   rx_over_set_a: assert property (FN_RX_PUSH && rx_full && !rx_rst_reg |=>
      rx_over_reg && $stable(rx_wptr_reg))
      else $error("receive overflow missing");

   rx_full_pin_a: assert property (1'b1 |->
      FN_RX_FULL == (rx_fill == 4'h8))
      else $error("receive full pin wrong");

   clear_empty_a: assert property (tx_clr_reg |=>
      tx_fill == 4'h0)
      else $error("clear left bytes");

   fill_bound_a: assert property (1'b1 |->
      tx_fill <= 4'h8 && rx_fill <= 4'h8)
      else $error("fill out of range");

   irq_level_a: assert property (!wr_msk |=>
      IRQ == |(int_stat_reg & int_mask_reg))
      else $error("interrupt level wrong");

   status_clear_a: assert property (rd_ist && !ev_under && !ev_over && !FN_RX_DONE |=>
      int_stat_reg == 2'h0)
      else $error("status not cleared");

endmodule : ep0_fifo_status

// file: sim/ep0_fifo_status_and_rx_count_tb.sv
`timescale 1ns/1ps
`include "ep0_fifo_regs.svh"
module ep0_fifo_status_and_rx_count_tb
   import ep0_fifo_pkg::*;
;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   byte_t ADDR = 8'h00;
   byte_t WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   wire byte_t RDATA;
   wire logic IRQ;
   wire logic FN_TX_POP;
   wire byte_t FN_TX_DATA;
   wire logic FN_RX_PUSH;
   wire byte_t FN_RX_DATA;
   wire logic FN_RX_DONE;
   wire logic FN_RX_FULL;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #12.5 CLK = ~CLK;
   ep0_fifo_status dut_u (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .FN_TX_POP(FN_TX_POP), .FN_TX_DATA(FN_TX_DATA),
      .FN_RX_PUSH(FN_RX_PUSH), .FN_RX_DATA(FN_RX_DATA), .FN_RX_DONE(FN_RX_DONE),
      .FN_RX_FULL(FN_RX_FULL));
   ep0_fn_model fn_u (.CLK(CLK), .FN_TX_POP(FN_TX_POP), .FN_RX_PUSH(FN_RX_PUSH),
      .FN_RX_DATA(FN_RX_DATA), .FN_RX_DONE(FN_RX_DONE));
   task automatic summarize();
      $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic chk(input byte_t seen, input byte_t exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input byte_t a, input byte_t d);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rchk(input byte_t a, input byte_t exp);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk(RDATA, exp);
   endtask : rchk
   task automatic t_reset();
      rchk(`OFF_TX_FLAGS, 8'h08);
      rchk(`OFF_RX_LEN, 8'h00);
      chk({7'h00, IRQ}, 8'h00);
      $display("Reset values done");
   endtask : t_reset
   task automatic t_tx_over();
      wr(`OFF_INT_MASK, 8'h03);
      for (int i = 0; i < 8; i++) wr(`OFF_TX_DATA, 8'(i));
      rchk(`OFF_TX_FLAGS, 8'h04);
      wr(`OFF_TX_FLAGS, 8'hff);
      rchk(`OFF_TX_FLAGS, 8'h04);
      wr(`OFF_TX_DATA, 8'hee);
      rchk(`OFF_TX_FLAGS, 8'h05);
      chk({7'h00, IRQ}, 8'h01);
      wr(`OFF_FIFO_CTL, 8'h01);
      repeat (2) @(posedge CLK);
      rchk(`OFF_TX_FLAGS, 8'h08);
      chk({7'h00, IRQ}, 8'h00);
      $display("Transmit overflow done");
   endtask : t_tx_over
   task automatic t_tx_under();
      wr(`OFF_TX_DATA, 8'ha5);
      fn_u.pop();
      #1 chk(FN_TX_DATA, 8'ha5);
      rchk(`OFF_TX_FLAGS, 8'h08);
      fn_u.pop();
      rchk(`OFF_TX_FLAGS, 8'h0a);
      chk({7'h00, IRQ}, 8'h01);
      rchk(`OFF_INT_STAT, 8'h01);
      wr(`OFF_FIFO_CTL, 8'h01);
      repeat (2) @(posedge CLK);
      rchk(`OFF_TX_FLAGS, 8'h08);
      $display("Transmit underflow done");
   endtask : t_tx_under
   task automatic t_rx();
      fn_u.push(8'h11, 1'b0);
      fn_u.push(8'h22, 1'b0);
      fn_u.push(8'h33, 1'b1);
      rchk(`OFF_RX_LEN, 8'h03);
      rchk(`OFF_RX_DATA, 8'h11);
      rchk(`OFF_RX_LEN, 8'h03);
      rchk(`OFF_RX_DATA, 8'h22);
      rchk(`OFF_RX_DATA, 8'h33);
      rchk(`OFF_RX_LEN, 8'h03);
      rchk(`OFF_RX_DATA, 8'h00);
      rchk(`OFF_FIFO_CTL, 8'h50);
      fn_u.push(8'h44, 1'b1);
      wr(`OFF_FIFO_CTL, 8'h80);
      repeat (2) @(posedge CLK);
      rchk(`OFF_FIFO_CTL, 8'h40);
      rchk(`OFF_RX_LEN, 8'h01);
      $display("Receive path done");
   endtask : t_rx
   task automatic t_rx_full();
      rchk(`OFF_INT_MASK, 8'h03);
      chk({7'h00, IRQ}, 8'h01);
      rchk(`OFF_INT_STAT, 8'h02);
      chk({7'h00, IRQ}, 8'h00);
      for (int i = 0; i < 8; i++) fn_u.push(8'(i + 16), 1'b0);
      #1 chk({7'h00, FN_RX_FULL}, 8'h01);
      rchk(`OFF_RX_LEN, 8'h01);
      fn_u.push(8'h99, 1'b0);
      fn_u.done();
      rchk(`OFF_RX_LEN, 8'h08);
      rchk(`OFF_FIFO_CTL, 8'h20);
      rchk(`OFF_RX_DATA, 8'h10);
      #1 chk({7'h00, FN_RX_FULL}, 8'h00);
      wr(`OFF_FIFO_CTL, 8'h80);
      repeat (2) @(posedge CLK);
      rchk(`OFF_FIFO_CTL, 8'h40);
      $display("Receive full done");
   endtask : t_rx_full
   initial begin
      repeat (8) @(posedge CLK);
      RST_N <= 1'b1;
      t_reset();
      t_tx_over();
      t_tx_under();
      t_rx();
      t_rx_full();
      summarize();
   end
endmodule : ep0_fifo_status_and_rx_count_tb

// file: sim/ep0_fn_model.sv
`timescale 1ns/1ps
module ep0_fn_model
   import ep0_fifo_pkg::*;
(
   input wire logic CLK,
   output logic FN_TX_POP,
   output logic FN_RX_PUSH,
   output byte_t FN_RX_DATA,
   output logic FN_RX_DONE
);
   initial begin
      FN_TX_POP = 1'b0;
      FN_RX_PUSH = 1'b0;
      FN_RX_DATA = 8'h00;
      FN_RX_DONE = 1'b0;
   end
   // Fetch one transmit byte, one-cycle pulse
   task automatic pop();
      @(posedge CLK);
      FN_TX_POP <= 1'b1;
      @(posedge CLK);
      FN_TX_POP <= 1'b0;
   endtask : pop
   // Push one byte, end of transaction marked on the last one
   task automatic push(input byte_t d, input logic last);
      @(posedge CLK);
      FN_RX_PUSH <= 1'b1;
      FN_RX_DATA <= d;
      FN_RX_DONE <= last;
      @(posedge CLK);
      FN_RX_PUSH <= 1'b0;
      FN_RX_DONE <= 1'b0;
      FN_RX_DATA <= ~d; // Released data shows junk
   endtask : push
   // End a transaction in a cycle that carries no byte
   task automatic done();
      @(posedge CLK);
      FN_RX_DONE <= 1'b1;
      @(posedge CLK);
      FN_RX_DONE <= 1'b0;
   endtask : done
endmodule : ep0_fn_model
